// ===== rtl/arb_regs.svh
// Constants of the external bus arbitration logic.
`ifndef ARB_REGS_SVH
`define ARB_REGS_SVH
`define ARB_SYNC_STAGES 2
`define ARB_GRANT_BIT 0
`define ARB_LOCK_BIT 1
`define ARB_PIN_COUNT 2
`endif

// ===== rtl/arb_pkg.sv
// Types of the external bus arbitration logic.
package arb_pkg;
  typedef enum logic [1:0] {
    st_reset,
    st_ext_own,
    st_implicit_own,
    st_explicit_own
  } arb_state_e;

  typedef struct packed {
    logic bus_request_out;
    logic bus_driven_out_n;
    logic drive_bus;
    logic start_allowed;
  } arb_out_s;
endpackage

// ===== rtl/pin_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
module pin_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reset_value,
  input wire logic d,
  output logic q
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // Reset loads 1 into both stages; reset_value is tied at instantiation but not used.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

  logic unused_reset_value;
  assign unused_reset_value = reset_value;
endmodule

// ===== rtl/bus_arbiter.sv
// External bus ownership state machine for two-wire and multi-master arbitration.
// How it works
// (R1) Only one master owns the bus.
// (R2) Two-wire mode uses grant and bus-driven only.
// (R3) Multi-master mode also uses the bus request.
// (R4) State changes only on rising clock edge; reset_n low loads st_reset at once, without a clock edge.
// (R5) Grant tied low means always granted.
// (R6) Grant and bus-driven pins are active low.
// (R7) Lock bit set keeps the bus after ungrant.
// (R8) Idle external master drives grant low.
// (R9) External master raises grant to reclaim bus.
// (R10) Pending request with grant low drives bus-driven.
// (R11) Ungrant mid-cycle releases only at cycle end.
// (R12) Burst transfers count as one cycle.
// (R13) Granted request: bus-driven, start, hold to end.
// (R14) Ungranted at cycle end, unlocked: drop bus-driven.
// (R15) Granted explicit owner keeps driving the bus.
// (R16) Granted, idle, unlocked: implicit owner, no drive.
// (R17) Request or lock moves implicit to explicit.
// (R18) Request-caused ownership starts transfer at once.
// (R19) Lock-caused ownership drives bus, withholds start.
// (R20) Transfer may start the cycle after grant.
// (R21) External master stops driving before granting.
// (R22) Reset holds bus-driven negated, bus undriven.
`include "arb_regs.svh"
module bus_arbiter
  import arb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic watchdog_reset,
  input wire logic grant_in_n,
  input wire logic bus_lock_bit,
  input wire logic internal_request,
  input wire logic cycle_active,
  input wire logic cycle_end,
  output logic bus_driven_out_n,
  output logic bus_request_out,
  output logic bus_drive_oe,
  output logic transfer_start_ok,
  output arb_state_e arb_state
);
  logic grant_sync_n;
  arb_state_e state;
  arb_state_e next_state;
  arb_out_s outs;
  logic granted;
  logic in_cycle;
  logic next_in_cycle;

  // Grant comes from another master's logic, so it is synchronised first.
  pin_sync grant_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .reset_value(1'b1),
    .d(grant_in_n),
    .q(grant_sync_n)
  );

  assign granted = !grant_sync_n; // see (R6)

  // A burst or burst-inhibited access is reported by the core as one long
  // cycle: cycle_active stays high across all of its transfers.
  always_comb begin
    next_in_cycle = in_cycle;
    if (cycle_end) begin
      next_in_cycle = 1'b0; // see (R12)
    end else if (cycle_active) begin
      next_in_cycle = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      st_reset: begin
        if (watchdog_reset) begin
          next_state = st_reset;
        end else if (granted) begin
          next_state = st_implicit_own; // see (R5)
        end else begin
          next_state = st_ext_own;
        end
      end
      st_implicit_own, st_ext_own: begin
        if (!granted) begin
          next_state = st_ext_own; // see (R9)
        end else if (bus_lock_bit || internal_request) begin
          next_state = st_explicit_own; // see (R17) (R20)
        end else begin
          next_state = st_implicit_own; // see (R16)
        end
      end
      st_explicit_own: begin
        if (granted) begin
          next_state = st_explicit_own; // see (R15)
        end else if (bus_lock_bit) begin
          next_state = st_explicit_own; // see (R7)
        end else if ((cycle_active || in_cycle) && !cycle_end) begin
          next_state = st_explicit_own; // see (R11) (R12)
        end else begin
          next_state = st_ext_own; // see (R14) (R1)
        end
      end
    endcase
    if (watchdog_reset) begin
      next_state = st_reset;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin // see (R4)
    if (!reset_n) begin
      state <= st_reset; // see (R22)
      in_cycle <= 1'b0;
    end else begin
      state <= next_state;
      in_cycle <= next_in_cycle;
    end
  end

  // Bus-driven follows the explicit state only, so the device never drives
  // while the external master owns or while reset holds it.
  always_comb begin
    outs.bus_driven_out_n = !(state == st_explicit_own); // see (R10) (R13) (R22)
    outs.drive_bus = (state == st_explicit_own); // see (R15) (R19) (R1)
    outs.start_allowed = (state == st_explicit_own) && internal_request; // see (R18) (R19)
    outs.bus_request_out = internal_request && (state != st_explicit_own)
      && (state != st_reset); // see (R3) (R2)
  end

  assign bus_driven_out_n = outs.bus_driven_out_n;
  assign bus_drive_oe = outs.drive_bus;
  assign transfer_start_ok = outs.start_allowed;
  assign bus_request_out = outs.bus_request_out;
  assign arb_state = state;
endmodule

// ===== sim/bus_arbiter_checker.sv
// Checker that ties the ownership outputs to grant, lock and cycle inputs.
module bus_arbiter_checker
  import arb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic watchdog_reset,
  input wire logic grant_in_n,
  input wire logic bus_lock_bit,
  input wire logic internal_request,
  input wire logic cycle_active,
  input wire logic cycle_end,
  input wire logic bus_driven_out_n,
  input wire logic bus_request_out,
  input wire logic bus_drive_oe,
  input wire logic transfer_start_ok,
  input wire arb_state_e arb_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic own = arb_state == st_explicit_own;
  wire logic in_reset = arb_state == st_reset;
  wire logic wd = !watchdog_reset;
  a_drive_follows: assert property (
    bus_driven_out_n == !own && bus_drive_oe == own)
    else $error("bus driven disagrees with state");
  a_start_gate: assert property (transfer_start_ok == (own && internal_request))
    else $error("start permission wrong");
  // The request output stays low in the reset state, where no ownership is sought.
  a_request_out: assert property (bus_request_out ==
    (internal_request && !own && !in_reset))
    else $error("bus request wrong");
  a_lock_hold: assert property (own && bus_lock_bit && wd |=> own)
    else $error("locked bus released");
  a_cycle_hold: assert property (own && cycle_active && !cycle_end && wd |=> own)
    else $error("bus released mid cycle");
  a_grant_take: assert property (
    (!grant_in_n && wd)[*3] ##0 internal_request |=> own)
    else $error("grant with request not taken");
  a_lock_take: assert property ((!grant_in_n && wd)[*3] ##0 bus_lock_bit |=> own)
    else $error("lock with grant not taken");
  a_ungrant_drop: assert property ((grant_in_n && wd)[*3] ##0 !bus_lock_bit && !cycle_active
    |=> arb_state == st_ext_own && bus_driven_out_n)
    else $error("bus kept after ungrant");
  a_wd_reset: assert property (
    watchdog_reset |=> arb_state == st_reset && !bus_drive_oe)
    else $error("watchdog reset ignored");
  c_implicit: cover property (arb_state == st_implicit_own);
  c_lock_kept: cover property (own && grant_in_n && bus_lock_bit);
  c_cycle_end: cover property (own && cycle_end);
endmodule
bind bus_arbiter bus_arbiter_checker u_chk (.*);

// ===== sim/ext_master.sv
// External master model that drives the grant pin from its hold request.
module ext_master (
  input wire logic ref_clk,
  input wire logic need,
  output logic grant_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] quiet = 2'h0;
  initial grant_in_n = 1'b1;
  // Two idle cycles pass before granting so its own drivers are off first.
  always @(negedge ref_clk) begin
    quiet <= need ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
    grant_in_n <= need || quiet < 2'h2;
  end
endmodule

// ===== sim/tb_two_wire_bus_arbitration.sv
// Random bench comparing the arbiter with a reference ownership model.
module tb_two_wire_bus_arbitration;
  import arb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, reset_n = 0, wdr = 0, lock = 0, req = 0, ca = 0, ce = 0, need = 1;
  logic grant_in_n, bd_n, br, oe, ok, g1, g2;
  logic [5:0] want;
  arb_state_e st;
  int error_cnt = 0, compares = 0, ms;
  logic [31:0] r = 32'hb855;
  ext_master u_ext_master (.ref_clk(ref_clk), .need(need), .grant_in_n(grant_in_n));
  bus_arbiter u_bus_arbiter (.ref_clk(ref_clk), .reset_n(reset_n), .watchdog_reset(wdr),
    .grant_in_n(grant_in_n), .bus_lock_bit(lock), .internal_request(req),
    .cycle_active(ca), .cycle_end(ce), .bus_driven_out_n(bd_n), .bus_request_out(br),
    .bus_drive_oe(oe), .transfer_start_ok(ok), .arb_state(st));
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic check(string what, logic [5:0] seen, logic [5:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] xorshift(logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic finish_test;
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) {ms, g1, g2} = {32'd0, 2'b11};
    else begin
      if (wdr) ms = 0;
      else if (g2) ms = (ms == 3 && (lock || ca && !ce)) ? 3 : 1;
      else ms = (ms != 0 && (lock || req || ms == 3)) ? 3 : 2;
      {g2, g1} = {g1, grant_in_n};
    end
    #2;
    // No bus request is raised while the arbiter sits in its reset state.
    want = {ms[1:0], ms != 3, ms == 3, ms == 3 && req, ms != 3 && ms != 0 && req};
    check("outputs", {st, bd_n, oe, ok, br}, want);
  end
  always @(negedge ref_clk) begin
    r = xorshift(r);
    ce <= ca && !ce && r[0];
    if (ce) ca <= 0;
    else if (ok === 1'b1) ca <= 1;
    lock <= lock ^ (r[7:3] == 0);
    req <= r[9:8] != 0;
    need <= need ^ (r[13:10] == 0);
    wdr <= r[20:14] == 0;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1;
    repeat (3000) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1;
    repeat (3000) @(posedge ref_clk);
    finish_test;
  end
  initial begin
    #300us;
    error_cnt++;
    finish_test;
  end
endmodule
